/* common/pcg_pkg.sv */
// Constants, register indices and field layout of the programmable CRC generator
`default_nettype none
package pcg_pkg;
    // Register indices on the 3-bit register port
    localparam logic [2:0] REG_CONTROL_STATUS = 3'h0;
    localparam logic [2:0] REG_WIDTH_LENGTH   = 3'h1;
    localparam logic [2:0] REG_POLY_LOW       = 3'h2;
    localparam logic [2:0] REG_POLY_HIGH      = 3'h3;
    localparam logic [2:0] REG_DATA_LOW       = 3'h4;
    localparam logic [2:0] REG_DATA_HIGH      = 3'h5;
    localparam logic [2:0] REG_RESULT_LOW     = 3'h6;
    localparam logic [2:0] REG_RESULT_HIGH    = 3'h7;

    // Control/status field positions
    localparam int BIT_ENABLE    = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int FLD_COUNT_LO  = 8;
    localparam int BIT_FULL      = 7;
    localparam int BIT_EMPTY     = 6;
    localparam int BIT_IRQ_SEL   = 5;
    localparam int BIT_GO        = 4;
    localparam int BIT_LSB_FIRST = 3;

    // Width/length configuration field positions
    localparam int FLD_WIDTH_LO  = 8;
    localparam int FLD_LENGTH_LO = 0;

    // FIFO depth selection by word width field
    localparam logic [4:0] WIDTH_DEEP4_ABOVE = 5'h0F;
    localparam logic [4:0] WIDTH_DEEP16_BELOW = 5'h08;
    localparam logic [4:0] DEPTH_4  = 5'h04;
    localparam logic [4:0] DEPTH_8  = 5'h08;
    localparam logic [4:0] DEPTH_16 = 5'h10;

    // Word bit positions and lane boundaries
    localparam logic [4:0] HALF_BOUNDARY = 5'h10;
    localparam logic [4:0] LANE_BOUNDARY = 5'h08;
    localparam logic [4:0] TOP_BIT       = 5'h1F;
    localparam logic [5:0] BITS_PER_CYCLE = 6'h02;

    // Reset values
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

    // Shift engine states, one-hot
    typedef enum logic [1:0] {
        PCG_ST_IDLE  = 2'b01,
        PCG_ST_SHIFT = 2'b10
    } pcg_state_t;
endpackage
`default_nettype wire

/* logic/pcg_crc32_generator.sv */
// Programmable CRC generator: register file, data FIFO and two-bit-per-cycle shift engine
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Polynomial length up to order 32
// - Set term bit enables XOR feedback
// - Constant and Nth terms always applied
// - Word width is width field plus one
// - FIFO depth 4, 8 or 16 by width
// - Byte writes; unused upper bits ignored
// - Writing word MSb position pushes one entry
// - Go and data: load word, decrement count
// - Shift two bits per cycle until empty
// - Full at depth, empty at zero
// - Disable clears FIFO, count, engine, data, result
// - Direction bit selects MSb or LSb first
// - Direction affects input only, result normal
// - Select 0: event on count one to zero
// - Select 1: event on hardware go clear
// - Hardware clears go on completion
// - Idle-stop halts engine in device idle
// - Count field readable at bits 12-8
// - Width at 12-8, length at 4-0
module pcg_crc32_generator #(
    parameter int FIFO_ENTRIES = 16
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic [1:0]  reg_byte_en,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        device_idle,
    output logic             crc_event_pulse
);

    // Whole state of the block; fifo storage is flip-flops indexed by pointer
    typedef struct packed {
        logic                         enable;
        logic                         idle_stop;
        logic                         irq_sel;
        logic                         go;
        logic                         lsb_first;
        logic [4:0]                   width_sel;
        logic [4:0]                   length_sel;
        logic [31:0]                  poly;
        logic [15:0]                  dat_lo;
        logic [15:0]                  dat_hi;
        logic [31:0]                  result;
        logic [FIFO_ENTRIES-1:0][31:0] fifo;
        logic [3:0]                   wr_ptr;
        logic [3:0]                   rd_ptr;
        logic [4:0]                   count;
        logic [31:0]                  shift_buf;
        logic [5:0]                   bits_left;
        pcg_pkg::pcg_state_t          state;
        logic [15:0]                  rdata;
        logic                         event_pulse;
    } pcg_regs_t;

    pcg_regs_t s_reg;
    pcg_regs_t s_next;

    // Mask keeping bits 0..msb
    function automatic logic [31:0] pcg_mask(input logic [4:0] msb);
        pcg_mask = pcg_pkg::ALL_ONES >> (pcg_pkg::TOP_BIT - msb);
    endfunction

    // Depth by width field
    function automatic logic [4:0] pcg_depth(input logic [4:0] wsel);
        if (wsel > pcg_pkg::WIDTH_DEEP4_ABOVE) begin
            pcg_depth = pcg_pkg::DEPTH_4;
        end else if (wsel >= pcg_pkg::WIDTH_DEEP16_BELOW) begin
            pcg_depth = pcg_pkg::DEPTH_8;
        end else begin
            pcg_depth = pcg_pkg::DEPTH_16;
        end
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] pcg_merge(input logic [15:0] old,
                                              input logic [15:0] wd,
                                              input logic [1:0]  be);
        pcg_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Reverse the low msb+1 bits so LSb-first words enter like MSb-first ones
    function automatic logic [31:0] pcg_reverse(input logic [31:0] d, input logic [4:0] msb);
        logic [31:0] r;
        r = pcg_pkg::RST_WORD;
        for (int i = 0; i < 32; i++) begin
            if (5'(i) <= msb) begin
                r[i] = d[msb - 5'(i)];
            end
        end
        pcg_reverse = r;
    endfunction

    // One bit through the engine
    function automatic logic [31:0] pcg_crc_bit(input logic [31:0] r,
                                                input logic        din,
                                                input logic [31:0] poly,
                                                input logic [4:0]  msb);
        logic        fb;
        logic [31:0] nr;
        // feedback from the top bit of the programmed length
        fb = r[msb] ^ din;
        nr = r << 1;
        // constant term forced, Nth term implied by feedback tap
        if (fb) begin
            nr = nr ^ (poly | 32'h0000_0001);
        end
        pcg_crc_bit = nr & pcg_mask(msb);
    endfunction

    logic [4:0]  depth;
    logic [3:0]  ptr_mask;
    logic        halt;
    logic        push;
    logic        pop;
    logic        word_done;
    logic [15:0] lo_new;
    logic [15:0] hi_new;
    logic [31:0] load_word;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [31:0] len_mask;

    // Next-state computation
    always_comb begin
        s_next      = s_reg;
        depth       = pcg_depth(s_reg.width_sel);
        len_mask    = pcg_mask(s_reg.length_sel);
        ptr_mask    = 4'(depth - 5'h01);
        halt        = s_reg.idle_stop & device_idle;
        push        = 1'b0;
        pop         = 1'b0;
        word_done   = 1'b0;
        lo_new      = s_reg.dat_lo;
        hi_new      = s_reg.dat_hi;
        load_word   = pcg_pkg::RST_WORD;
        r1          = s_reg.result;
        r2          = s_reg.result;
        s_next.event_pulse = 1'b0;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                pcg_pkg::REG_CONTROL_STATUS: begin
                    if (reg_byte_en[1]) begin
                        s_next.enable    = reg_wdata[pcg_pkg::BIT_ENABLE];
                        s_next.idle_stop = reg_wdata[pcg_pkg::BIT_IDLE_STOP];
                    end
                    if (reg_byte_en[0]) begin
                        s_next.irq_sel   = reg_wdata[pcg_pkg::BIT_IRQ_SEL];
                        s_next.go        = reg_wdata[pcg_pkg::BIT_GO];
                        s_next.lsb_first = reg_wdata[pcg_pkg::BIT_LSB_FIRST];
                    end
                end
                pcg_pkg::REG_WIDTH_LENGTH: begin
                    // width field high byte, length field low byte
                    if (reg_byte_en[1]) begin
                        s_next.width_sel = reg_wdata[pcg_pkg::FLD_WIDTH_LO +: 5];
                    end
                    if (reg_byte_en[0]) begin
                        s_next.length_sel = reg_wdata[pcg_pkg::FLD_LENGTH_LO +: 5];
                    end
                end
                pcg_pkg::REG_POLY_LOW: begin
                    s_next.poly[15:0] = pcg_merge(s_reg.poly[15:0], reg_wdata, reg_byte_en)
                                        & 16'hFFFE;
                end
                pcg_pkg::REG_POLY_HIGH: begin
                    s_next.poly[31:16] = pcg_merge(s_reg.poly[31:16], reg_wdata, reg_byte_en);
                end
                pcg_pkg::REG_DATA_LOW: begin
                    lo_new = pcg_merge(s_reg.dat_lo, reg_wdata, reg_byte_en);
                    // lane holding the word MSb completes the entry
                    if (s_reg.width_sel < pcg_pkg::HALF_BOUNDARY) begin
                        push = (s_reg.width_sel >= pcg_pkg::LANE_BOUNDARY) ? reg_byte_en[1]
                                                                           : reg_byte_en[0];
                    end
                end
                pcg_pkg::REG_DATA_HIGH: begin
                    hi_new = pcg_merge(s_reg.dat_hi, reg_wdata, reg_byte_en);
                    // upper-half MSb completes a wide entry
                    if (s_reg.width_sel >= pcg_pkg::HALF_BOUNDARY) begin
                        push = ((s_reg.width_sel - pcg_pkg::HALF_BOUNDARY) >=
                                pcg_pkg::LANE_BOUNDARY) ? reg_byte_en[1] : reg_byte_en[0];
                    end
                end
                pcg_pkg::REG_RESULT_LOW: begin
                    s_next.result[15:0] = pcg_merge(s_reg.result[15:0], reg_wdata,
                                                    reg_byte_en);
                end
                pcg_pkg::REG_RESULT_HIGH: begin
                    s_next.result[31:16] = pcg_merge(s_reg.result[31:16], reg_wdata,
                                                     reg_byte_en);
                end
                default: begin
                end
            endcase
        end
        s_next.dat_lo = lo_new;
        s_next.dat_hi = hi_new;

        // Push into the FIFO; a word written while full is dropped
        if (push && (s_reg.count < depth)) begin
            s_next.fifo[s_reg.wr_ptr] = {hi_new, lo_new} & pcg_mask(s_reg.width_sel);
            s_next.wr_ptr = (s_reg.wr_ptr + 4'h1) & ptr_mask;
        end else begin
            push = 1'b0;
        end

        // Shift engine
        case (s_reg.state)
            pcg_pkg::PCG_ST_IDLE: begin
                // start when go and data present
                if (s_reg.go && (s_reg.count != 5'h00) && !halt) begin
                    pop = 1'b1;
                end
            end
            pcg_pkg::PCG_ST_SHIFT: begin
                if (!halt) begin
                    // two bits per cycle, one on an odd tail
                    r1 = pcg_crc_bit(s_reg.result, s_reg.shift_buf[31], s_reg.poly,
                                     s_reg.length_sel);
                    r2 = pcg_crc_bit(r1, s_reg.shift_buf[30], s_reg.poly, s_reg.length_sel);
                    if (s_reg.bits_left >= pcg_pkg::BITS_PER_CYCLE) begin
                        s_next.result    = r2;
                        s_next.shift_buf = s_reg.shift_buf << 2;
                        s_next.bits_left = s_reg.bits_left - pcg_pkg::BITS_PER_CYCLE;
                    end else begin
                        s_next.result    = r1;
                        s_next.shift_buf = s_reg.shift_buf << 1;
                        s_next.bits_left = 6'h00;
                    end
                    word_done = (s_reg.bits_left <= pcg_pkg::BITS_PER_CYCLE);
                    if (word_done) begin
                        if (s_reg.go && (s_reg.count != 5'h00)) begin
                            pop = 1'b1;
                        end else begin
                            s_next.state = pcg_pkg::PCG_ST_IDLE;
                            if (s_reg.go && (s_reg.count == 5'h00)) begin
                                s_next.go = 1'b0;
                                if (s_reg.irq_sel) begin
                                    s_next.event_pulse = 1'b1;
                                end
                                // A go set in this very cycle keeps the engine armed
                                if (reg_wr && (reg_addr == pcg_pkg::REG_CONTROL_STATUS) &&
                                    reg_byte_en[0] && reg_wdata[pcg_pkg::BIT_GO]) begin
                                    s_next.go = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
            default: begin
                s_next.state = pcg_pkg::PCG_ST_IDLE;
            end
        endcase

        // Load the next word into the shift buffer, MSb aligned to bit 31
        if (pop) begin
            load_word = s_reg.fifo[s_reg.rd_ptr];
            // LSb-first words are reversed before entry
            // only input order changes, result stays normal
            if (s_reg.lsb_first) begin
                load_word = pcg_reverse(load_word, s_reg.width_sel);
            end
            s_next.shift_buf = load_word << (pcg_pkg::TOP_BIT - s_reg.width_sel);
            // word width is field plus one
            s_next.bits_left = {1'b0, s_reg.width_sel} + 6'h01;
            s_next.rd_ptr    = (s_reg.rd_ptr + 4'h1) & ptr_mask;
            s_next.state     = pcg_pkg::PCG_ST_SHIFT;
        end

        s_next.count = s_reg.count + {4'h0, push} - {4'h0, pop};
        if (!s_reg.irq_sel && (s_reg.count == 5'h01) && (s_next.count == 5'h00)) begin
            s_next.event_pulse = 1'b1;
        end

        // disabled module: FIFO, engine, data and result held clear
        if (!s_next.enable) begin
            s_next.wr_ptr    = 4'h0;
            s_next.rd_ptr    = 4'h0;
            s_next.count     = 5'h00;
            s_next.state     = pcg_pkg::PCG_ST_IDLE;
            s_next.shift_buf = pcg_pkg::RST_WORD;
            s_next.bits_left = 6'h00;
            s_next.dat_lo    = pcg_pkg::RST_HALF;
            s_next.dat_hi    = pcg_pkg::RST_HALF;
            s_next.result    = pcg_pkg::RST_WORD;
        end

        // Read data registered, valid the cycle after the strobe only
        s_next.rdata = pcg_pkg::RST_HALF;
        if (reg_rd) begin
            case (reg_addr)
                pcg_pkg::REG_CONTROL_STATUS: begin
                    s_next.rdata[pcg_pkg::BIT_ENABLE]    = s_reg.enable;
                    s_next.rdata[pcg_pkg::BIT_IDLE_STOP] = s_reg.idle_stop;
                    s_next.rdata[pcg_pkg::FLD_COUNT_LO +: 5] = s_reg.count;
                    s_next.rdata[pcg_pkg::BIT_FULL]      = (s_reg.count == depth);
                    s_next.rdata[pcg_pkg::BIT_EMPTY]     = (s_reg.count == 5'h00);
                    s_next.rdata[pcg_pkg::BIT_IRQ_SEL]   = s_reg.irq_sel;
                    s_next.rdata[pcg_pkg::BIT_GO]        = s_reg.go;
                    s_next.rdata[pcg_pkg::BIT_LSB_FIRST] = s_reg.lsb_first;
                end
                pcg_pkg::REG_WIDTH_LENGTH: begin
                    s_next.rdata[pcg_pkg::FLD_WIDTH_LO +: 5]  = s_reg.width_sel;
                    s_next.rdata[pcg_pkg::FLD_LENGTH_LO +: 5] = s_reg.length_sel;
                end
                pcg_pkg::REG_POLY_LOW: begin
                    s_next.rdata = s_reg.poly[15:0];
                end
                pcg_pkg::REG_POLY_HIGH: begin
                    s_next.rdata = s_reg.poly[31:16];
                end
                pcg_pkg::REG_DATA_LOW: begin
                    s_next.rdata = s_reg.dat_lo;
                end
                pcg_pkg::REG_DATA_HIGH: begin
                    s_next.rdata = s_reg.dat_hi;
                end
                pcg_pkg::REG_RESULT_LOW: begin
                    s_next.rdata = s_reg.result[15:0] & len_mask[15:0];
                end
                pcg_pkg::REG_RESULT_HIGH: begin
                    s_next.rdata = s_reg.result[31:16] & len_mask[31:16];
                end
                default: begin
                end
            endcase
        end
    end

    // State register; clock enable low freezes everything, bus strobes included
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_reg       <= '0;
            s_reg.state <= pcg_pkg::PCG_ST_IDLE;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata       = s_reg.rdata;
    assign crc_event_pulse = s_reg.event_pulse;

endmodule
`default_nettype wire

/* sim/pcg_crc32_assertions.sv */
// Concurrent checks on the register port of the CRC generator
`timescale 1ns/100ps
`default_nettype none
module pcg_crc32_checker #(
    parameter int FIFO_ENTRIES = 16
) (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [1:0]  reg_byte_en,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        device_idle,
    input wire logic        crc_event_pulse
);
    logic [15:0] cfg_reg;
    logic [15:0] poly_lo_reg;
    logic [15:0] poly_hi_reg;
    logic [31:0] len_mask;
    logic [4:0]  depth;

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
                                          input logic [1:0] be);
        return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
    endfunction

    // Shadow of software settings; the enable bit must not disturb these
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_reg     <= 16'h0000;
            poly_lo_reg <= 16'h0000;
            poly_hi_reg <= 16'h0000;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == pcg_pkg::REG_WIDTH_LENGTH)
                cfg_reg <= merge(cfg_reg, reg_wdata, reg_byte_en);
            if (reg_addr == pcg_pkg::REG_POLY_LOW)
                poly_lo_reg <= merge(poly_lo_reg, reg_wdata, reg_byte_en);
            if (reg_addr == pcg_pkg::REG_POLY_HIGH)
                poly_hi_reg <= merge(poly_hi_reg, reg_wdata, reg_byte_en);
        end
    end

    // Result mask and FIFO depth worked out from the shadowed settings
    always_comb begin
        len_mask = ~(32'hFFFF_FFFE << cfg_reg[4:0]);
        if (cfg_reg[12:8] > 5'h0F) depth = 5'h04;
        else if (cfg_reg[12:8] >= 5'h08) depth = 5'h08;
        else depth = 5'h10;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_read(logic [2:0] a);
        clk_en && reg_rd && reg_addr == a;
    endsequence

    a_rdata_one_cycle: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside the answer cycle");
    a_status_reserved: assert property (s_read(pcg_pkg::REG_CONTROL_STATUS) |=>
        reg_rdata[14] == 1'b0 && reg_rdata[2:0] == 3'h0)
        else $error("unused status bits not zero");
    a_empty_tracks_count: assert property (s_read(pcg_pkg::REG_CONTROL_STATUS) |=>
        reg_rdata[6] == (reg_rdata[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    a_full_at_depth: assert property (s_read(pcg_pkg::REG_CONTROL_STATUS) |=>
        reg_rdata[7] == (reg_rdata[12:8] == depth) && reg_rdata[12:8] <= FIFO_ENTRIES)
        else $error("full flag disagrees with depth");
    a_cfg_readback: assert property (s_read(pcg_pkg::REG_WIDTH_LENGTH) |=>
        reg_rdata == (cfg_reg & 16'h1F1F))
        else $error("width and length readback wrong");
    a_poly_low_readback: assert property (s_read(pcg_pkg::REG_POLY_LOW) |=>
        reg_rdata == (poly_lo_reg & 16'hFFFE))
        else $error("low term readback wrong");
    a_poly_high_readback: assert property (s_read(pcg_pkg::REG_POLY_HIGH) |=>
        reg_rdata == poly_hi_reg)
        else $error("high term readback wrong");
    a_result_low_mask: assert property (s_read(pcg_pkg::REG_RESULT_LOW) |=>
        (reg_rdata & ~len_mask[15:0]) == 16'h0000)
        else $error("low result bits above length set");
    a_result_high_mask: assert property (s_read(pcg_pkg::REG_RESULT_HIGH) |=>
        (reg_rdata & ~len_mask[31:16]) == 16'h0000)
        else $error("high result bits above length set");
endmodule

bind pcg_crc32_generator pcg_crc32_checker #(.FIFO_ENTRIES(FIFO_ENTRIES)) u_chk (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .device_idle(device_idle), .crc_event_pulse(crc_event_pulse)
);
`default_nettype wire

/* sim/pcg_crc32_tb.sv */
// Self-checking testbench for the CRC generator
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        clk_en = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0]  reg_byte_en = 2'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        device_idle = 1'b0;
    logic [15:0] reg_rdata;
    logic        crc_event_pulse;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          ev_count = 0;
    int          ev_cycle = 0;
    logic [31:0] exp_crc;

    always #2.5 core_clk = ~core_clk;

    pcg_crc32_generator #(.FIFO_ENTRIES(16)) u_dut (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .device_idle(device_idle), .crc_event_pulse(crc_event_pulse)
    );

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Cycle count, event log and hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (crc_event_pulse === 1'b1) begin
            ev_count++;
            ev_cycle = cycles;
        end
        if (cycles == 20000) begin
            fail_count++;
            $display("[ERR] %0t timeout", $time);
            end_of_test;
        end
    end

    // Reference: normal CRC, only the word's low w bits enter
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d,
                                             input logic [31:0] p, input int n, input int w,
                                             input bit lsb);
        logic [31:0] m;
        logic f;
        m = (n == 32) ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1;
        for (int i = 0; i < w; i++) begin
            f = (lsb ? d[i] : d[w - 1 - i]) ^ c[n - 1];
            c = (c << 1) & m;
            if (f) c = c ^ ((p | 32'h1) & m);
        end
        return c;
    endfunction

    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_byte_en <= be;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask

    // Narrow words go in as one byte, wide ones low half first
    task automatic push(input int w, input logic [31:0] d);
        wr(3'h4, d[15:0], (w < 8) ? 2'h1 : 2'h3);
        if (w > 15) wr(3'h5, d[31:16], 2'h3);
    endtask

    // Bounded poll until hardware drops the go bit
    task automatic wait_done;
        logic [15:0] s;
        for (int i = 0; i < 100; i++) begin
            rd(3'h0, s);
            if (s[4] === 1'b0) break;
        end
        chk({15'h0000, s[4]}, 16'h0000);
    endtask

    task automatic t_reset;
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            chk(d, (i == 0) ? 16'h0040 : 16'h0000);
        end
        $display("test reset values done");
    endtask

    task automatic t_msb;
        logic [15:0] d;
        int e0;
        e0 = ev_count;
        wr(3'h0, 16'hA000, 2'h3);
        wr(3'h1, 16'h050F, 2'h3);
        wr(3'h2, 16'h1021, 2'h3);
        wr(3'h3, 16'h0001, 2'h3);
        wr(3'h6, 16'h0000, 2'h3);
        wr(3'h7, 16'h0000, 2'h3);
        rd(3'h2, d);
        chk(d, 16'h1020);
        push(5, 32'h0000_00FF);
        push(5, 32'h0000_00C5);
        rd(3'h0, d);
        chk(d, 16'hA200);
        @(posedge core_clk);
        device_idle <= 1'b1;
        wr(3'h0, 16'hA010, 2'h3);
        repeat (20) @(posedge core_clk);
        rd(3'h0, d);
        chk({15'h0000, d[4]}, 16'h0001);
        rd(3'h6, d);
        chk(d, 16'h0000);
        @(posedge core_clk);
        device_idle <= 1'b0;
        wait_done;
        exp_crc = crc_step(crc_step(32'h0, 32'hFF, 32'h1_1021, 16, 6, 1'b0),
                           32'hC5, 32'h1_1021, 16, 6, 1'b0);
        rd(3'h6, d);
        chk(d, exp_crc[15:0]);
        rd(3'h7, d);
        chk(d, 16'h0000);
        chk(16'(ev_count - e0), 16'h0001);
        $display("test msb first done");
    endtask

    task automatic t_lsb;
        logic [15:0] d;
        int e0;
        int c0;
        e0 = ev_count;
        wr(3'h0, 16'h8008, 2'h3);
        wr(3'h1, 16'h1F1F, 2'h3);
        wr(3'h2, 16'h1DB7, 2'h3);
        wr(3'h3, 16'h04C1, 2'h3);
        wr(3'h6, 16'h0000, 2'h3);
        wr(3'h7, 16'h0000, 2'h3);
        push(31, 32'h1234_5678);
        push(31, 32'hCAFE_F00D);
        wr(3'h0, 16'h8038, 2'h3);
        // Idle without idle-stop must not halt the engine
        device_idle <= 1'b1;
        c0 = cycles;
        wait_done;
        exp_crc = crc_step(crc_step(32'h0, 32'h1234_5678, 32'h04C1_1DB7, 32, 32, 1'b1),
                           32'hCAFE_F00D, 32'h04C1_1DB7, 32, 32, 1'b1);
        rd(3'h6, d);
        chk(d, exp_crc[15:0]);
        rd(3'h7, d);
        chk(d, exp_crc[31:16]);
        chk(16'(ev_count - e0), 16'h0001);
        chk({15'h0000, (ev_cycle - c0) >= 31 && (ev_cycle - c0) <= 36}, 16'h0001);
        $display("test lsb first done");
    endtask

    task automatic t_depth;
        logic [15:0] d;
        int w[5] = '{7, 8, 15, 16, 31};
        int dp[5] = '{16, 8, 8, 4, 4};
        wr(3'h0, 16'h0000, 2'h3);
        rd(3'h6, d);
        chk(d, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            wr(3'h0, 16'h0000, 2'h3);
            wr(3'h0, 16'h8000, 2'h3);
            wr(3'h1, {3'h0, w[k][4:0], 8'h1F}, 2'h3);
            for (int i = 0; i < dp[k]; i++) push(w[k], 32'hFFFF_FFFF);
            rd(3'h0, d);
            chk({9'h000, d[12:6]}, {9'h000, dp[k][4:0], 2'b10});
            push(w[k], 32'hFFFF_FFFF);
            rd(3'h0, d);
            chk({9'h000, d[12:6]}, {9'h000, dp[k][4:0], 2'b10});
        end
        // A disable written while the clock enable is low is lost
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(3'h0, 16'h0000, 2'h3);
        clk_en <= 1'b1;
        rd(3'h0, d);
        chk({11'h000, d[12:8]}, 16'h0004);
        wr(3'h0, 16'h0000, 2'h3);
        rd(3'h0, d);
        chk(d, 16'h0040);
        rd(3'h4, d);
        chk(d, 16'h0000);
        $display("test fifo depth done");
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        t_reset;
        t_msb;
        t_lsb;
        t_depth;
        end_of_test;
    end
endmodule
`default_nettype wire
